// [core/tto_pkg.sv]
// Purpose: Shared constants and types for the turn-on timeout fault response block
// Assumes: 200 MHz core clock; settings arrive as decoded command-code accesses
// Notes:   Time values in the settings use the 16-bit linear (exponent/mantissa) format
package tto_pkg;

  // Command codes of the settings held by this block
  localparam logic [7:0]  TTO_CODE_LIMIT   = 8'h62;  // Turn-on time limit, linear ms
  localparam logic [7:0]  TTO_CODE_REACT   = 8'h63;  // Timeout reaction byte
  localparam logic [7:0]  TTO_CODE_TOFF    = 8'h64;  // Turn-off wait time, linear ms
  localparam logic [7:0]  TTO_CODE_UNIT    = 8'hc8;  // Fault delay time unit, linear ms

  // Reset values of the settings
  localparam logic [15:0] TTO_RST_LIMIT    = 16'h0000;  // No limit
  localparam logic [7:0]  TTO_RST_REACT    = 8'h00;     // Ignore, no retry, 1 unit
  localparam logic [15:0] TTO_RST_TOFF     = 16'h0000;  // No turn-off wait
  localparam logic [15:0] TTO_RST_UNIT     = 16'h0001;  // One ms per unit

  // Reaction field codes
  localparam logic [1:0]  TTO_RESP_IGNORE  = 2'h0;  // Keep regulating
  localparam logic [1:0]  TTO_RESP_DELAY   = 2'h1;  // Run for delay, then retry logic
  localparam logic [1:0]  TTO_RESP_RETRY   = 2'h2;  // Disable now, then retry logic
  localparam logic [1:0]  TTO_RESP_RESUME  = 2'h3;  // Off while fault persists
  localparam logic [2:0]  TTO_RETRY_NONE   = 3'h0;  // No restart attempt
  localparam logic [2:0]  TTO_RETRY_FOREVER = 3'h7; // Unlimited restarts

  // Timing: one ms expressed in core clock cycles
  localparam int unsigned TTO_CLK_PERIOD_PS = 5000;        // 200 MHz
  localparam int unsigned TTO_MS_PS         = 1000000000;  // One millisecond
  localparam int unsigned TTO_CYC_PER_MS    = TTO_MS_PS / TTO_CLK_PERIOD_PS;

  // Reaction byte layout: response 7:6, retries 5:3, delay 2:0
  typedef struct packed {
    logic [1:0] resp;   // Response action
    logic [2:0] retry;  // Retry setting
    logic [2:0] dly;    // Delay exponent
  } tto_react_t;

  // Command-code access from the bus engine
  typedef struct packed {
    logic        wr;    // Write strobe, one cycle
    logic        rd;    // Read strobe, one cycle
    logic [7:0]  code;  // Command code
    logic [15:0] data;  // Write data, low byte only for byte settings
  } tto_cmd_t;

  // Read answer toward the bus engine
  typedef struct packed {
    logic        ack;   // One-cycle answer strobe
    logic        hit;   // Code belongs to this block
    logic [15:0] data;  // Read data
  } tto_rsp_t;

  // Linear format to whole milliseconds; negative values count as zero
  function automatic logic [31:0] tto_lin_ms(input logic [15:0] v);
    logic [31:0] m;
    logic [4:0]  e;
    m = {21'h000000, v[10:0]};
    e = v[15:11];
    if (v[10]) begin
      m = 32'h00000000;
    end
    if (e[4]) begin
      return m >> (5'h00 - e);
    end
    return m << e;
  endfunction : tto_lin_ms

endpackage : tto_pkg

// [core/tto_ms_timer.sv]
// Purpose: Millisecond down-counter shared by all waits of the fault response
// Assumes: Load is a one-cycle strobe from logic on the same clock
// Notes:   Done is a level that stays high until the next load
`timescale 1ns/1ps
`default_nettype none
module tto_ms_timer
  import tto_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = TTO_CYC_PER_MS  // Clock cycles per ms
) (
  input  wire logic        clk_in,      // Core clock
  input  wire logic        nrst_in,     // Async reset, active low
  input  wire logic        load_in,     // Start a new wait
  input  wire logic [31:0] load_ms_in,  // Wait length in ms
  output var  logic        done_out     // Wait elapsed
);

  localparam int PW = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;  // Prescaler width

  // Refuse a prescaler that cannot count
  if (CYC_PER_MS < 2) begin : g_chk
    $error("tto_ms_timer: CYC_PER_MS must be at least 2");
  end

  logic [31:0]   ms_q,   ms_d;    // Remaining ms
  logic [PW-1:0] pre_q,  pre_d;   // Cycles left in current ms
  logic          done_q, done_d;  // Elapsed flag

  // Next-value logic: reload restarts the prescaler so every wait is whole ms
  always_comb begin
    ms_d   = ms_q;
    pre_d  = pre_q;
    done_d = done_q;
    if (load_in) begin
      ms_d   = load_ms_in;
      pre_d  = PW'(CYC_PER_MS - 1);
      done_d = (load_ms_in == 32'h00000000);  // Zero wait ends at once
    end else if (!done_q) begin
      if (pre_q == '0) begin
        pre_d = PW'(CYC_PER_MS - 1);
        if (ms_q <= 32'h00000001) begin
          ms_d   = 32'h00000000;
          done_d = 1'b1;
        end else begin
          ms_d = ms_q - 32'h00000001;
        end
      end else begin
        pre_d = pre_q - PW'(1);
      end
    end
  end

  // State registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ms_q   <= 32'h00000000;
      pre_q  <= '0;
      done_q <= 1'b1;
    end else begin
      ms_q   <= ms_d;
      pre_q  <= pre_d;
      done_q <= done_d;
    end
  end

  assign done_out = done_q;

endmodule : tto_ms_timer
`default_nettype wire

// [core/tto_fault_resp.sv]
// Purpose: Turn-on timeout detection and fault response sequencing
// Assumes: Run command and output-good comparator are asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module tto_fault_resp
  import tto_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = TTO_CYC_PER_MS  // Shorten for simulation
) (
  input  wire logic     clk_in,          // Core clock, 200 MHz
  input  wire logic     nrst_in,         // Async reset, active low
  input  wire tto_cmd_t cmd_in,          // Command-code access
  input  wire logic     run_cmd_in,      // Output commanded on (pin/operation)
  input  wire logic     vout_ok_in,      // Output above undervoltage threshold
  input  wire logic     clear_fault_in,  // Clear faults strobe, same clock
  input  wire logic     other_fault_in,  // Another fault forces shutdown
  output var  tto_rsp_t rsp_out,         // Read answer
  output var  logic     pwr_on_out,      // Power stage enabled
  output var  logic     fall_start_out,  // Output fall begins, pulse
  output var  logic     fault_out,       // Timeout fault flag
  output var  logic [2:0] tries_out      // Restart attempts used
);

  // One-hot sequencer states
  typedef enum logic [7:0] {
    ST_OFF    = 8'h01,  // Output off, idle
    ST_START  = 8'h02,  // Ramping up, limit running
    ST_RUN    = 8'h04,  // Regulating
    ST_CONT   = 8'h08,  // Running through fault delay
    ST_WAIT   = 8'h10,  // Off, waiting to restart
    ST_HOLD   = 8'h20,  // Off until fault cleared
    ST_RESUME = 8'h40,  // Off while fault persists
    ST_STOP   = 8'h80   // Turn-off wait before fall
  } tto_state_t;

  tto_state_t  st_q, st_d;             // Sequencer state
  logic [15:0] limit_q, limit_d;       // Turn-on time limit setting
  tto_react_t  react_q, react_d;       // Reaction setting
  logic [15:0] toff_q, toff_d;         // Turn-off wait setting
  logic [15:0] unit_q, unit_d;         // Fault time unit setting
  logic [2:0]  tries_q, tries_d;       // Attempts used
  logic        fault_q, fault_d;       // Timeout fault flag
  logic        pwr_q, pwr_d;           // Power enable
  logic        fall_q, fall_d;         // Fall start pulse
  tto_rsp_t    rsp_q, rsp_d;           // Read answer
  logic [1:0]  run_sync_q;             // Run command synchroniser
  logic [1:0]  vok_sync_q;             // Output-good synchroniser
  logic        run_cmd;                // Synchronised run command
  logic        vout_ok;                // Synchronised output good
  logic [31:0] limit_ms;               // Limit in ms
  logic [31:0] toff_ms;                // Turn-off wait in ms
  logic [31:0] unit_ms;                // One delay unit in ms
  logic [31:0] delay_ms;               // Decoded delay in ms
  logic        lim_zero;               // Timeout disabled
  logic        tm_load;                // Restart timer
  logic [31:0] tm_ms;                  // Timer load value
  logic        tm_done;                // Timer elapsed
  logic        tmo_evt;                // Timeout detected this cycle

  // Two-flop synchronisers for the asynchronous levels
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_sync_q <= 2'h0;
      vok_sync_q <= 2'h0;
    end else begin
      run_sync_q <= {run_sync_q[0], run_cmd_in};
      vok_sync_q <= {vok_sync_q[0], vout_ok_in};
    end
  end
  assign run_cmd = run_sync_q[1];
  assign vout_ok = vok_sync_q[1];

  // Time decoding of the settings
  assign limit_ms = tto_lin_ms(limit_q);
  assign toff_ms  = tto_lin_ms(toff_q);
  assign unit_ms  = tto_lin_ms(unit_q);             // Shared fault unit
  assign delay_ms = unit_ms << react_q.dly;         // 1..128 units
  assign lim_zero = (limit_ms == 32'h00000000);     // No timeout
  assign tmo_evt  = (st_q == ST_START) && !vout_ok && !lim_zero && tm_done;

  // Settings writes and reads, decoded by command code
  always_comb begin
    limit_d = limit_q;
    react_d = react_q;
    toff_d  = toff_q;
    unit_d  = unit_q;
    rsp_d   = '0;
    if (cmd_in.wr) begin
      if (cmd_in.code == TTO_CODE_LIMIT) begin
        limit_d = cmd_in.data;
      end else if (cmd_in.code == TTO_CODE_REACT) begin
        react_d = cmd_in.data[7:0];
      end else if (cmd_in.code == TTO_CODE_TOFF) begin
        toff_d = cmd_in.data;
      end else if (cmd_in.code == TTO_CODE_UNIT) begin
        unit_d = cmd_in.data;
      end
    end
    if (cmd_in.rd) begin
      rsp_d.ack = 1'b1;
      rsp_d.hit = 1'b1;
      if (cmd_in.code == TTO_CODE_LIMIT) begin
        rsp_d.data = limit_q;
      end else if (cmd_in.code == TTO_CODE_REACT) begin
        rsp_d.data = {8'h00, react_q};
      end else if (cmd_in.code == TTO_CODE_TOFF) begin
        rsp_d.data = toff_q;
      end else if (cmd_in.code == TTO_CODE_UNIT) begin
        rsp_d.data = unit_q;
      end else begin
        rsp_d.hit = 1'b0;                 // Not ours, reads zero
      end
    end
  end

  // Settings and answer registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      limit_q <= TTO_RST_LIMIT;
      react_q <= TTO_RST_REACT;
      toff_q  <= TTO_RST_TOFF;
      unit_q  <= TTO_RST_UNIT;
      rsp_q   <= '0;
    end else begin
      limit_q <= limit_d;
      react_q <= react_d;
      toff_q  <= toff_d;
      unit_q  <= unit_d;
      rsp_q   <= rsp_d;
    end
  end

  // Sequencer next state; timer reloads on every state change
  always_comb begin
    st_d    = st_q;
    tries_d = tries_q;
    fault_d = fault_q;
    fall_d  = 1'b0;
    if (tmo_evt) begin
      fault_d = 1'b1;                     // Set wins over a clear
    end else if (clear_fault_in) begin
      fault_d = 1'b0;                     // Cleared by the host
    end
    if (other_fault_in) begin
      st_d    = ST_OFF;                   // Another fault shuts down
      tries_d = 3'h0;
    end else if (!run_cmd && (st_q != ST_OFF) && (st_q != ST_STOP)) begin
      tries_d = 3'h0;                     // Commanded off
      if (pwr_q) begin
        st_d = ST_STOP;                   // Wait before fall
      end else begin
        st_d = ST_OFF;
      end
    end else begin
      case (st_q)
        ST_OFF: begin
          if (run_cmd) begin
            st_d = ST_START;
          end
        end
        ST_START: begin
          if (vout_ok) begin
            st_d    = ST_RUN;
            tries_d = 3'h0;               // Started well
          end else if (tmo_evt) begin
            case (react_q.resp)
              TTO_RESP_IGNORE: st_d = ST_RUN;     // Keep regulating
              TTO_RESP_DELAY:  st_d = ST_CONT;    // Keep running
              TTO_RESP_RETRY:  st_d = ST_HOLD;    // Off now, retry below
              default:         st_d = ST_RESUME;
            endcase
          end
        end
        ST_RUN: begin
          if (clear_fault_in) begin
            tries_d = 3'h0;
          end
        end
        ST_CONT: begin
          if (tm_done) begin
            if (vout_ok) begin
              st_d    = ST_RUN;
              tries_d = 3'h0;
            end else begin
              st_d = ST_HOLD;             // Retry logic below
            end
          end
        end
        ST_WAIT: begin
          if (tm_done) begin
            st_d = ST_START;              // Next attempt
          end
        end
        ST_HOLD: begin
          if (clear_fault_in) begin
            st_d    = ST_OFF;
            tries_d = 3'h0;
          end
        end
        ST_RESUME: begin
          if (clear_fault_in || vout_ok) begin
            st_d = ST_START;              // Fault gone, enable again
          end
        end
        ST_STOP: begin
          if (run_cmd) begin
            st_d = ST_START;
          end else if (tm_done) begin
            st_d   = ST_OFF;
            fall_d = 1'b1;                // Fall starts now
          end
        end
        default: st_d = ST_OFF;
      endcase
      // A disable that may retry: choose wait or hold by the retry setting
      if ((st_d == ST_HOLD) && (st_q != ST_HOLD)) begin
        if (react_q.retry == TTO_RETRY_FOREVER) begin
          st_d = ST_WAIT;                 // Unlimited
        end else if ((react_q.retry != TTO_RETRY_NONE) && (tries_q < react_q.retry)) begin
          st_d    = ST_WAIT;              // Attempts remain
          tries_d = tries_q + 3'h1;
        end
      end
    end
    pwr_d = (st_d == ST_START) || (st_d == ST_RUN) || (st_d == ST_CONT) || (st_d == ST_STOP);
  end

  // Timer load value for the state being entered
  always_comb begin
    tm_load = (st_d != st_q);
    tm_ms   = 32'h00000000;
    case (st_d)
      ST_START: tm_ms = limit_ms;
      ST_CONT:  tm_ms = delay_ms;
      ST_WAIT:  tm_ms = delay_ms;
      ST_STOP:  tm_ms = toff_ms;
      default:  tm_ms = 32'h00000000;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q    <= ST_OFF;
      tries_q <= 3'h0;
      fault_q <= 1'b0;
      pwr_q   <= 1'b0;
      fall_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      tries_q <= tries_d;
      fault_q <= fault_d;
      pwr_q   <= pwr_d;
      fall_q  <= fall_d;
    end
  end

  // Shared millisecond wait timer
  tto_ms_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_timer (
    .clk_in     (clk_in),
    .nrst_in    (nrst_in),
    .load_in    (tm_load),
    .load_ms_in (tm_ms),
    .done_out   (tm_done)
  );

  assign rsp_out        = rsp_q;
  assign pwr_on_out     = pwr_q;
  assign fall_start_out = fall_q;
  assign fault_out      = fault_q;
  assign tries_out      = tries_q;

  // Checks of the response behaviour
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_tmo;
    tmo_evt && !other_fault_in && run_cmd;
  endsequence

  sequence s_off_now;
    !pwr_q ##1 !pwr_q;
  endsequence

  a_ignore_keeps_on: assert property (s_tmo and (react_q.resp == TTO_RESP_IGNORE)
    |=> pwr_q && st_q == ST_RUN) else $error("ignore response dropped output");
  a_delay_runs_on: assert property (s_tmo and (react_q.resp == TTO_RESP_DELAY)
    |=> st_q == ST_CONT && pwr_q) else $error("delay response did not keep running");
  a_disable_at_once: assert property (s_tmo and (react_q.resp == TTO_RESP_RETRY)
    |=> s_off_now) else $error("disable response left output on");
  a_resume_stays_off: assert property (st_q == ST_RESUME |-> !pwr_q)
    else $error("output on while fault persists");
  a_no_retry_hold: assert property (s_tmo and (react_q.resp == TTO_RESP_RETRY)
    and (react_q.retry == TTO_RETRY_NONE) |=> st_q == ST_HOLD)
    else $error("restart attempted with retry off");
  a_retry_count_cap: assert property (st_q == ST_WAIT && react_q.retry != TTO_RETRY_FOREVER
    |-> tries_q <= react_q.retry && tries_q != 3'h0) else $error("attempt count beyond setting");
  a_retry_spacing: assert property (st_q != ST_WAIT && st_d == ST_WAIT |-> tm_load
    && tm_ms == (unit_ms << react_q.dly)) else $error("restart spacing wrong");
  a_endless_retry: assert property (st_q == ST_WAIT && tm_done && run_cmd
    && !other_fault_in |=> st_q == ST_START ##1 pwr_q) else $error("retry did not restart");
  a_delay_decode: assert property (react_q.dly == 3'h7
    |-> delay_ms == unit_ms * 32'h00000080) else $error("delay decode wrong");
  a_toff_fall: assert property (st_q == ST_STOP && tm_done && !run_cmd
    && !other_fault_in |=> fall_q && !pwr_q ##1 !fall_q) else $error("no fall after wait");
  a_timeout_flag: assert property (tmo_evt |=> fault_q)
    else $error("timeout fault not raised");
  a_no_limit: assert property (st_q == ST_START && lim_zero && !vout_ok && run_cmd
    && !other_fault_in |=> st_q == ST_START && pwr_q) else $error("gave up with zero limit");
  a_tries_clear: assert property (st_q == ST_START && vout_ok && run_cmd
    && !other_fault_in |=> tries_q == 3'h0) else $error("attempts not cleared on start");

endmodule : tto_fault_resp
`default_nettype wire

// [bench/tto_host.sv]
// Purpose: Host-side model that writes and reads the fault response settings
// Assumes: Requests change at the falling edge and are taken at the next rising edge
// Notes:   Released fields show inverted values so that stale data is never reused
`timescale 1ns/1ps
`default_nettype none
module tto_host
  import tto_pkg::*;
(
  input  wire logic     clk_in,  // Core clock
  input  wire tto_rsp_t rsp_in,  // Read answer
  output var  tto_cmd_t cmd_out  // Command access
);
  initial cmd_out = '0;

  // Single write, only supported codes are sent
  task automatic write(input logic [7:0] code, input logic [15:0] data);
    @(negedge clk_in);
    cmd_out = '{wr: 1'b1, rd: 1'b0, code: code, data: data};
    @(negedge clk_in);
    cmd_out = '{wr: 1'b0, rd: 1'b0, code: ~code, data: ~data};
  endtask : write

  // Single read, answer sampled in the cycle after the taking edge
  task automatic read(input logic [7:0] code, output tto_rsp_t r);
    @(negedge clk_in);
    cmd_out = '{wr: 1'b0, rd: 1'b1, code: code, data: 16'h5a5a};
    @(negedge clk_in);
    r = rsp_in;
    cmd_out = '{wr: 1'b0, rd: 1'b0, code: ~code, data: 16'ha5a5};
  endtask : read
endmodule : tto_host
`default_nettype wire

// [bench/tto_fault_resp_tb.sv]
// Purpose: Self-checking bench of the turn-on timeout fault response
// Assumes: One ms shortened to 4 clock cycles; inputs change at the falling edge
// Notes:   Output stage is played by the bench through vout_ok_in
`timescale 1ns/1ps
`default_nettype none
module tto_fault_resp_tb;
  import tto_pkg::*;
  localparam int unsigned CPM = 4;  // Cycles per ms in simulation
  logic       clk_in = 1'b0;          // Core clock
  logic       nrst_in = 1'b0;         // Reset, active low
  logic       run_cmd_in = 1'b0;      // Output commanded on
  logic       vout_ok_in = 1'b0;      // Output above threshold
  logic       clear_fault_in = 1'b0;  // Clear strobe
  logic       other_fault_in = 1'b0;  // Other shutdown fault
  tto_cmd_t   cmd_in;                 // Host access
  tto_rsp_t   rsp_out;                // Read answer
  logic       pwr_on_out;             // Power stage on
  logic       fall_start_out;         // Fall pulse
  logic       fault_out;              // Timeout fault
  logic [2:0] tries_out;              // Attempts used
  int         error_cnt = 0;          // Mismatches
  int         check_count = 0;        // Comparisons
  int         cyc = 0;                // Watchdog count
  int         n;                      // Measured cycles
  tto_rsp_t   r;                      // Read result

  always #2.5 clk_in = ~clk_in;

  tto_fault_resp #(.CYC_PER_MS(CPM)) i_tto_fault_resp (
    .clk_in(clk_in), .nrst_in(nrst_in), .cmd_in(cmd_in), .run_cmd_in(run_cmd_in),
    .vout_ok_in(vout_ok_in), .clear_fault_in(clear_fault_in),
    .other_fault_in(other_fault_in), .rsp_out(rsp_out), .pwr_on_out(pwr_on_out),
    .fall_start_out(fall_start_out), .fault_out(fault_out), .tries_out(tries_out));

  tto_host i_tto_host (.clk_in(clk_in), .rsp_in(rsp_out), .cmd_out(cmd_in));

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Closing report
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog against hangs
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // Wait for pwr (0), fault (1) or fall pulse (2) to reach a level, bounded
  task automatic wait_for(input int sel, input logic val, input int max, output int k);
    logic s;
    k = 0;
    s = (sel == 0) ? pwr_on_out : (sel == 1) ? fault_out : fall_start_out;
    while (s !== val && k < max) begin
      @(negedge clk_in);
      k++;
      s = (sel == 0) ? pwr_on_out : (sel == 1) ? fault_out : fall_start_out;
    end
  endtask : wait_for

  // Measured count inside a window
  task automatic in_range(input int k, input int lo, input int hi);
    check(32'(k >= lo && k <= hi), 32'h1);
  endtask : in_range

  // Remove run, clear fault, back to idle
  task automatic idle();
    run_cmd_in = 1'b0;
    vout_ok_in = 1'b0;
    other_fault_in = 1'b0;
    repeat (4) @(negedge clk_in);
    clear_fault_in = 1'b1;
    @(negedge clk_in);
    clear_fault_in = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask : idle

  // Settings reset values, byte storage and an unmapped code
  task automatic t_regs();
    logic [7:0]  codes [4] = '{8'h62, 8'h63, 8'h64, 8'hc8};
    logic [15:0] rst [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001};
    for (int i = 0; i < 4; i++) begin
      i_tto_host.read(codes[i], r);
      check({r.ack, r.hit, r.data}, {2'b11, rst[i]});
    end
    i_tto_host.write(8'h63, 16'hab5a);
    i_tto_host.read(8'h63, r);
    check(r.data, 16'h005a);
    i_tto_host.read(8'h65, r);
    check({r.ack, r.hit, r.data}, {2'b10, 16'h0000});
  endtask : t_regs

  // Zero limit: no fault however long the output stays low
  task automatic t_nolimit();
    i_tto_host.write(8'h62, 16'h0000);
    run_cmd_in = 1'b1;
    wait_for(0, 1'b1, 10, n);
    repeat (60) @(negedge clk_in);
    check({fault_out, pwr_on_out}, 2'b01);
    idle();
    i_tto_host.write(8'h62, 16'h0001);
  endtask : t_nolimit

  // Generic run with a reaction byte; returns after the first fault
  task automatic start_fault(input logic [7:0] react);
    i_tto_host.write(8'h63, {8'h00, react});
    run_cmd_in = 1'b1;
    wait_for(0, 1'b1, 10, n);
    check(pwr_on_out, 1'b1);
    wait_for(1, 1'b1, 20, n);
    check(fault_out, 1'b1);
  endtask : start_fault

  // Ignore: output keeps running
  task automatic t_ignore();
    start_fault(8'h00);
    repeat (20) @(negedge clk_in);
    check(pwr_on_out, 1'b1);
    idle();
  endtask : t_ignore

  // Disable and retry twice, two units apart, then off until clear
  task automatic t_retry();
    start_fault(8'h91);
    check(pwr_on_out, 1'b0);
    for (int a = 1; a <= 2; a++) begin
      wait_for(0, 1'b1, 30, n);
      in_range(n, 2 * CPM - 1, 2 * CPM + 3);
      check(tries_out, 3'(a));
      wait_for(0, 1'b0, 20, n);
    end
    repeat (40) @(negedge clk_in);
    check({pwr_on_out, tries_out}, 4'h2);
    idle();
    check({fault_out, tries_out}, 4'h0);
  endtask : t_retry

  // No retry: stays off, clear lets it start again
  task automatic t_noretry();
    start_fault(8'h80);
    repeat (40) @(negedge clk_in);
    check({pwr_on_out, tries_out}, 4'h0);
    clear_fault_in = 1'b1;
    @(negedge clk_in);
    clear_fault_in = 1'b0;
    wait_for(0, 1'b1, 12, n);
    check(pwr_on_out, 1'b1);
    idle();
  endtask : t_noretry

  // Keep running for four units of two ms each, then disable
  task automatic t_delay();
    i_tto_host.write(8'hc8, 16'h0002);
    start_fault(8'h42);
    wait_for(0, 1'b0, 40, n);
    in_range(n, 8 * CPM - 1, 8 * CPM + 3);
    idle();
    i_tto_host.write(8'hc8, 16'h0001);
  endtask : t_delay

  // Off while fault persists, resume once the output is good
  task automatic t_resume();
    start_fault(8'hc0);
    wait_for(0, 1'b0, 3, n);
    check(pwr_on_out, 1'b0);
    vout_ok_in = 1'b1;
    wait_for(0, 1'b1, 12, n);
    check(pwr_on_out, 1'b1);
    idle();
  endtask : t_resume

  // Unlimited retries beyond six, stopped by another fault
  task automatic t_forever();
    start_fault(8'hb8);
    for (int a = 0; a < 8; a++) begin
      wait_for(0, 1'b1, 20, n);
      check(pwr_on_out, 1'b1);
      wait_for(0, 1'b0, 20, n);
    end
    other_fault_in = 1'b1;
    repeat (3) @(negedge clk_in);
    check({pwr_on_out, tries_out}, 4'h0);
    idle();
  endtask : t_forever

  // Turn-off wait of two ms before the fall starts
  task automatic t_toff();
    i_tto_host.write(8'h62, 16'h0000);
    i_tto_host.write(8'h64, 16'h0002);
    run_cmd_in = 1'b1;
    vout_ok_in = 1'b1;
    wait_for(0, 1'b1, 10, n);
    run_cmd_in = 1'b0;
    repeat (2 * CPM) @(negedge clk_in);
    check(pwr_on_out, 1'b1);
    wait_for(2, 1'b1, 20, n);
    check({fall_start_out, pwr_on_out}, 2'b10);
    in_range(n, 0, 6);
    idle();
  endtask : t_toff

  // Main sequence
  initial begin
    repeat (16) @(negedge clk_in);
    nrst_in = 1'b1;
    t_regs();
    t_nolimit();
    t_ignore();
    t_retry();
    t_noretry();
    t_delay();
    t_resume();
    t_forever();
    t_toff();
    report_and_stop();
  end
endmodule : tto_fault_resp_tb
`default_nettype wire
